// [hdl/nvc_irq_ctrl.v]
/*
 * Nested vectored interrupt controller: APB register file, pending and
 * enable state, priority selection, stacking and vector fetch sequencer.
 * Assumes the core answers stack and vector requests on the same clock
 * and pulses i_exc_return when a handler ends.
 */
// Function
// - 32 request lines, four priority levels
// - Strictly higher new priority preempts running handler
// - Handler address read from vector table
// - Line n uses vector n+16, address times four
// - Push eight core registers, pop on return
// - Pending at return chains without restore
// - Higher request during entry replaces selection
// - Level 0 most urgent, reset to zero
// - Reset, NMI, hard fault fixed above all
// - Write-1 set/clear enable, both read back
// - Write-1 set/clear pending, both read back
// - Disabled request pends but does not activate
// - Disabling active line leaves it active
// - Clearing pending never touches active state
// - 8-bit priority fields, four per word
// - Line 28 wake request, some lines reserved
// - Line 22 ORs three serial interface requests
// - Every exception except reset runs in handler mode
`timescale 1ns/10ps
`default_nettype none
`include "nvc_defines.vh"

module nvc_irq_ctrl #(
  parameter NUM_IRQ = 32
) (
  input wire i_ref_clk,
  input wire i_rst_n,
  // APB slave
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output wire o_pready,
  output wire o_pslverr,
  // Interrupt sources, asynchronous levels
  input wire [NUM_IRQ-1:0] i_irq_lines,
  input wire [2:0] i_universal_serial_irq,
  input wire i_power_down_wakeup_irq,
  input wire i_nmi,
  input wire i_hard_fault,
  // Stack sequencing towards the core
  output reg o_stk_req,
  output reg o_stk_push,
  output reg [2:0] o_stk_idx,
  input wire i_stk_ack,
  // Vector table read
  output reg o_vec_req,
  output wire [31:0] o_vec_addr,
  input wire i_vec_ack,
  input wire [31:0] i_vec_data,
  // Handler control
  output reg o_branch,
  output reg [31:0] o_handler_addr,
  output wire o_handler_mode,
  output wire [5:0] o_active_vec,
  input wire i_exc_return
);

  ////////////////////////////////////////////////////////////////////////
  // Input synchronisation and line composition

  wire [NUM_IRQ+5:0] raw_in;
  wire [NUM_IRQ+5:0] syn_in;
  reg [NUM_IRQ-1:0] line_lvl;
  reg nmi_dly_q;
  reg hard_dly_q;

  assign raw_in = {i_hard_fault, i_nmi, i_power_down_wakeup_irq,
                   i_universal_serial_irq, i_irq_lines};

  nvc_sync #(.WIDTH(NUM_IRQ + 6)) u_sync (
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_async(raw_in),
    .o_sync(syn_in)
  );

  // Shared and wake lines replace their slots; reserved lines stay quiet
  always @* begin
    line_lvl = syn_in[NUM_IRQ-1:0];
    line_lvl[`NVC_LINE_USCI] = |syn_in[NUM_IRQ+2:NUM_IRQ];
    line_lvl[`NVC_LINE_PWRWU] = syn_in[NUM_IRQ+3];
    line_lvl = line_lvl & ~`NVC_RSVD_MASK;
  end

  ////////////////////////////////////////////////////////////////////////
  // APB decode

  wire [5:0] reg_idx = i_paddr[7:2];
  wire setup_ph = i_psel & ~i_penable;
  wire wr_en = i_psel & i_penable & i_pwrite;
  reg mapped;

  always @* begin
    mapped = (i_paddr[11:8] == 4'h0) && (i_paddr[1:0] == 2'b00) &&
             (reg_idx <= `NVC_OFF_STATUS);
  end

  // Zero wait states; read data is captured during the setup cycle
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & ~mapped;

  wire w_seten = wr_en && mapped && (reg_idx == `NVC_OFF_SETEN);
  wire w_clren = wr_en && mapped && (reg_idx == `NVC_OFF_CLREN);
  wire w_setpend = wr_en && mapped && (reg_idx == `NVC_OFF_SETPEND);
  wire w_clrpend = wr_en && mapped && (reg_idx == `NVC_OFF_CLRPEND);
  wire w_prio = wr_en && mapped && (reg_idx >= `NVC_OFF_PRIO0) &&
                (reg_idx <= `NVC_OFF_PRIO7);
  wire [2:0] prio_word = reg_idx[2:0] - 3'h4;

  ////////////////////////////////////////////////////////////////////////
  // State registers

  reg [NUM_IRQ-1:0] en_q, en_d;
  reg [NUM_IRQ-1:0] pend_q, pend_d;
  reg [NUM_IRQ-1:0] act_q, act_d;
  reg [2*NUM_IRQ-1:0] prio_q;
  reg nmi_pend_q, nmi_act_q, hard_pend_q, hard_act_q;
  reg [2:0] state_q;
  reg [5:0] sel_num_q;
  reg [2:0] sel_rank_q;
  reg [5:0] vec_num_q;
  reg push_done_q, fetch_done_q;

  ////////////////////////////////////////////////////////////////////////
  // Ranking: running level and best candidate

  reg [2:0] exec_rank;
  reg [5:0] top_num;
  reg [2:0] best_rank;
  reg [5:0] best_num;
  reg [NUM_IRQ-1:0] cand;
  reg [2:0] rk;
  integer i, j, k;

  // Configured level k maps to rank 3+k, below the fixed exceptions
  always @* begin
    exec_rank = `NVC_RANK_NONE;
    top_num = 6'h00;
    best_rank = `NVC_RANK_NONE;
    best_num = 6'h00;
    rk = 3'h0;
    cand = pend_q & en_q & ~act_q;
    // Descending scan so the lowest line wins a tie
    for (i = NUM_IRQ - 1; i >= 0; i = i - 1) begin
      rk = `NVC_RANK_CFG0 + {1'b0, prio_q[2*i +: 2]};
      if (act_q[i] && rk <= exec_rank) begin
        exec_rank = rk;
        top_num = `NVC_VEC_IRQ0 + i[5:0];
      end
      if (cand[i] && rk <= best_rank) begin
        best_rank = rk;
        best_num = `NVC_VEC_IRQ0 + i[5:0];
      end
    end
    // Fixed ranks sit above every configurable level
    if (hard_act_q) begin
      exec_rank = `NVC_RANK_HARD;
      top_num = `NVC_VEC_HARD;
    end
    if (nmi_act_q) begin
      exec_rank = `NVC_RANK_NMI;
      top_num = `NVC_VEC_NMI;
    end
    if (hard_pend_q && !hard_act_q && `NVC_RANK_HARD < best_rank) begin
      best_rank = `NVC_RANK_HARD;
      best_num = `NVC_VEC_HARD;
    end
    if (nmi_pend_q && !nmi_act_q) begin
      best_rank = `NVC_RANK_NMI;
      best_num = `NVC_VEC_NMI;
    end
  end

  assign o_handler_mode = (exec_rank != `NVC_RANK_NONE);
  assign o_active_vec = top_num;
  assign o_vec_addr = {24'h0, vec_num_q, 2'b00};

  wire preempt = best_rank < exec_rank;
  wire late = best_rank < sel_rank_q;
  wire take = (state_q == `NVC_ST_ENTRY) && push_done_q && fetch_done_q &&
              !o_vec_req && !late;
  wire ret_clr = (state_q == `NVC_ST_RET);
  wire [5:0] sel_line = sel_num_q - `NVC_VEC_IRQ0;
  wire [5:0] top_line = top_num - `NVC_VEC_IRQ0;
  wire sel_is_irq = sel_num_q >= `NVC_VEC_IRQ0;
  wire top_is_irq = top_num >= `NVC_VEC_IRQ0;

  ////////////////////////////////////////////////////////////////////////
  // Enable, pending and active next values

  // Pending sets are applied last so they beat clears, hardware sets only on lines that are not active; an enable clear beats a set
  always @* begin
    en_d = (en_q | (w_seten ? i_pwdata : 32'h0)) &
           ~(w_clren ? i_pwdata : 32'h0);
    act_d = act_q;
    pend_d = pend_q & ~(w_clrpend ? i_pwdata : 32'h0);
    if (take && sel_is_irq) begin
      pend_d[sel_line[4:0]] = 1'b0;
      act_d[sel_line[4:0]] = 1'b1;
    end
    // Only an exception return retires an active line
    if (ret_clr && top_is_irq) begin
      act_d[top_line[4:0]] = 1'b0;
    end
    pend_d = pend_d | (w_setpend ? i_pwdata : 32'h0);
    // Level request pends regardless of enable, held off from activation on
    pend_d = pend_d | (line_lvl & ~act_d);
    pend_d = pend_d & ~`NVC_RSVD_MASK;
  end

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      en_q <= `NVC_EN_RST;
      pend_q <= `NVC_PEND_RST;
      act_q <= 32'h0;
    end else begin
      en_q <= en_d;
      pend_q <= pend_d;
      act_q <= act_d;
    end
  end

  // Priority fields keep only the upper two bits of each byte
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      prio_q <= `NVC_PRIO_RST;
    end else if (w_prio) begin
      for (j = 0; j < 4; j = j + 1) begin
        prio_q[(prio_word * 4 + j) * 2 +: 2] <=
          i_pwdata[j * `NVC_PRIO_FIELD_W + `NVC_PRIO_LSB +: 2];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Fixed exceptions: rising edge pends, activation and return retire

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      nmi_dly_q <= 1'b0;
      hard_dly_q <= 1'b0;
      nmi_pend_q <= 1'b0;
      nmi_act_q <= 1'b0;
      hard_pend_q <= 1'b0;
      hard_act_q <= 1'b0;
    end else begin
      nmi_dly_q <= syn_in[NUM_IRQ+4];
      hard_dly_q <= syn_in[NUM_IRQ+5];
      if (take && sel_num_q == `NVC_VEC_NMI) begin
        nmi_act_q <= 1'b1;
        nmi_pend_q <= 1'b0;
      end
      if (take && sel_num_q == `NVC_VEC_HARD) begin
        hard_act_q <= 1'b1;
        hard_pend_q <= 1'b0;
      end
      if (ret_clr && top_num == `NVC_VEC_NMI) begin
        nmi_act_q <= 1'b0;
      end
      if (ret_clr && top_num == `NVC_VEC_HARD) begin
        hard_act_q <= 1'b0;
      end
      // New edges win over the activation clear above
      if (syn_in[NUM_IRQ+4] && !nmi_dly_q) begin
        nmi_pend_q <= 1'b1;
      end
      if (syn_in[NUM_IRQ+5] && !hard_dly_q) begin
        hard_pend_q <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Entry, return and boot sequencer

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= `NVC_ST_BOOT;
      sel_num_q <= `NVC_VEC_RESET;
      sel_rank_q <= 3'h0;
      vec_num_q <= `NVC_VEC_RESET;
      push_done_q <= 1'b0;
      fetch_done_q <= 1'b0;
      o_stk_req <= 1'b0;
      o_stk_push <= 1'b0;
      o_stk_idx <= 3'h0;
      o_vec_req <= 1'b0;
      o_branch <= 1'b0;
      o_handler_addr <= 32'h0;
    end else begin
      o_branch <= 1'b0;
      case (state_q)
        // Reset vector, nothing can interrupt it
        `NVC_ST_BOOT: begin
          if (!o_vec_req) begin
            o_vec_req <= 1'b1;
            vec_num_q <= `NVC_VEC_RESET;
          end else if (i_vec_ack) begin
            o_vec_req <= 1'b0;
            o_handler_addr <= i_vec_data;
            o_branch <= 1'b1;
            state_q <= `NVC_ST_IDLE;
          end
        end
        `NVC_ST_IDLE: begin
          if (preempt) begin
            sel_num_q <= best_num;
            sel_rank_q <= best_rank;
            state_q <= `NVC_ST_ENTRY;
            o_stk_req <= 1'b1;
            o_stk_push <= 1'b1;
            o_stk_idx <= 3'h0;
            push_done_q <= 1'b0;
            fetch_done_q <= 1'b0;
            o_vec_req <= 1'b1;
            vec_num_q <= best_num;
          end else if (i_exc_return && o_handler_mode) begin
            state_q <= `NVC_ST_RET;
          end
        end
        // Stacking and vector fetch run side by side
        `NVC_ST_ENTRY: begin
          if (o_stk_req && i_stk_ack) begin
            if (o_stk_idx == `NVC_STK_LAST) begin
              o_stk_req <= 1'b0;
              push_done_q <= 1'b1;
            end else begin
              o_stk_idx <= o_stk_idx + 3'h1;
            end
          end
          if (late) begin
            sel_num_q <= best_num;
            sel_rank_q <= best_rank;
          end
          // A fetch answered for a stale selection is simply reissued
          if (o_vec_req) begin
            if (i_vec_ack) begin
              if (vec_num_q == sel_num_q && !late) begin
                o_vec_req <= 1'b0;
                fetch_done_q <= 1'b1;
                o_handler_addr <= i_vec_data;
              end else begin
                vec_num_q <= late ? best_num : sel_num_q;
              end
            end
          end else if (!fetch_done_q || late) begin
            o_vec_req <= 1'b1;
            fetch_done_q <= 1'b0;
            vec_num_q <= late ? best_num : sel_num_q;
          end
          if (take) begin
            o_branch <= 1'b1;
            state_q <= `NVC_ST_IDLE;
          end
        end
        // Running handler retires this cycle
        `NVC_ST_RET: begin
          state_q <= `NVC_ST_DECIDE;
        end
        `NVC_ST_DECIDE: begin
          if (preempt) begin
            // Frame stays on the stack; go straight to the next handler
            sel_num_q <= best_num;
            sel_rank_q <= best_rank;
            push_done_q <= 1'b1;
            fetch_done_q <= 1'b0;
            o_vec_req <= 1'b1;
            vec_num_q <= best_num;
            state_q <= `NVC_ST_ENTRY;
          end else begin
            o_stk_req <= 1'b1;
            o_stk_push <= 1'b0;
            o_stk_idx <= 3'h0;
            state_q <= `NVC_ST_POP;
          end
        end
        `NVC_ST_POP: begin
          if (i_stk_ack) begin
            if (o_stk_idx == `NVC_STK_LAST) begin
              o_stk_req <= 1'b0;
              state_q <= `NVC_ST_IDLE;
            end else begin
              o_stk_idx <= o_stk_idx + 3'h1;
            end
          end
        end
        default: begin
          state_q <= `NVC_ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data, loaded in the setup cycle so it stands in the access phase

  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_prdata <= 32'h0;
    end else if (setup_ph && !i_pwrite) begin
      o_prdata <= 32'h0;
      if (mapped) begin
        case (reg_idx)
          `NVC_OFF_SETEN, `NVC_OFF_CLREN: begin
            o_prdata <= en_q;
          end
          `NVC_OFF_SETPEND, `NVC_OFF_CLRPEND: begin
            o_prdata <= pend_q;
          end
          `NVC_OFF_ACTIVE: begin
            o_prdata <= act_q;
          end
          `NVC_OFF_STATUS: begin
            o_prdata <= {9'h000, state_q, 1'b0, exec_rank,
                         2'b00, best_num, 2'b00, top_num};
          end
          default: begin
            for (k = 0; k < 4; k = k + 1) begin
              o_prdata[k * `NVC_PRIO_FIELD_W + `NVC_PRIO_LSB +: 2] <=
                prio_q[(prio_word * 4 + k) * 2 +: 2];
            end
          end
        endcase
      end
    end
  end

endmodule

`default_nettype wire

// [hdl/nvc_sync.v]
/*
 * Two-flop synchroniser for a bundle of independent level inputs.
 * Assumes each bit is a slow level; no bus coherence is given.
 */
`timescale 1ns/10ps
`default_nettype none

module nvc_sync #(
  parameter WIDTH = 1
) (
  input wire i_ref_clk,
  input wire i_rst_n,
  input wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);

  reg [WIDTH-1:0] meta_q;
  reg [WIDTH-1:0] sync_q;

  // First stage feeds only the second stage
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= {WIDTH{1'b0}};
      sync_q <= {WIDTH{1'b0}};
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;

endmodule

`default_nettype wire

// [shared/nvc_defines.vh]
/*
 * Constants of the nested vectored interrupt controller: register
 * offsets, field positions, reset values, exception numbers and ranks.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef NVC_DEFINES_VH
`define NVC_DEFINES_VH

// Register word indices on the APB window
`define NVC_OFF_SETEN 6'h00
`define NVC_OFF_CLREN 6'h01
`define NVC_OFF_SETPEND 6'h02
`define NVC_OFF_CLRPEND 6'h03
`define NVC_OFF_PRIO0 6'h04
`define NVC_OFF_PRIO7 6'h0B
`define NVC_OFF_ACTIVE 6'h0C
`define NVC_OFF_STATUS 6'h0D

// Priority field: 8 bits per line, two upper bits implemented
`define NVC_PRIO_FIELD_W 8
`define NVC_PRIO_LSB 6
`define NVC_PRIO_RST 64'h0
`define NVC_EN_RST 32'h0
`define NVC_PEND_RST 32'h0

// Lines with no source, then the shared serial line and the wake line
`define NVC_RSVD_MASK 32'h08B3_0000
`define NVC_LINE_USCI 22
`define NVC_LINE_PWRWU 28

// Exception numbers
`define NVC_VEC_RESET 6'h01
`define NVC_VEC_NMI 6'h02
`define NVC_VEC_HARD 6'h03
`define NVC_VEC_IRQ0 6'h10

// Ranks: smaller is more urgent; 3..6 are configurable levels 0..3
`define NVC_RANK_NMI 3'h1
`define NVC_RANK_HARD 3'h2
`define NVC_RANK_CFG0 3'h3
`define NVC_RANK_NONE 3'h7

// Stack frame: R0..R3, R12, LR, PC, PSR
`define NVC_STK_LAST 3'h7

// Sequencer states
`define NVC_ST_BOOT 3'h0
`define NVC_ST_IDLE 3'h1
`define NVC_ST_ENTRY 3'h2
`define NVC_ST_RET 3'h3
`define NVC_ST_DECIDE 3'h4
`define NVC_ST_POP 3'h5

`endif

// [verif/nvc_core_model.sv]
/* Core side model: answers stack words and vector table reads.
   Assumes the controller clock; i_slow idle cycles precede each answer. */
`timescale 1ns/10ps
`default_nettype none
module nvc_core_model (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic [2:0] i_slow,
  input wire logic i_stk_req,
  input wire logic i_stk_push,
  input wire logic i_vec_req,
  input wire logic [31:0] i_vec_addr,
  output logic o_stk_ack,
  output logic o_vec_ack,
  output logic [31:0] o_vec_data,
  output logic [15:0] o_n_push,
  output logic [15:0] o_n_pop
);
  logic [2:0] stk_wait_q;
  logic [2:0] vec_wait_q;
  ////////////////////////////////////////
  // One answer per request; idle data toggles so stale reads show
  always @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      {o_stk_ack, o_vec_ack, stk_wait_q, vec_wait_q} <= 8'h00;
      {o_vec_data, o_n_push, o_n_pop} <= 64'h0;
    end else begin
      o_stk_ack <= 1'b0;
      o_vec_ack <= 1'b0;
      o_vec_data <= ~o_vec_data;
      if (i_stk_req && !o_stk_ack) begin
        stk_wait_q <= (stk_wait_q >= i_slow) ? 3'h0 : stk_wait_q + 3'h1;
        o_stk_ack <= (stk_wait_q >= i_slow);
        if (stk_wait_q >= i_slow && i_stk_push) o_n_push <= o_n_push + 16'h1;
        if (stk_wait_q >= i_slow && !i_stk_push) o_n_pop <= o_n_pop + 16'h1;
      end
      if (i_vec_req && !o_vec_ack) begin
        vec_wait_q <= (vec_wait_q >= i_slow) ? 3'h0 : vec_wait_q + 3'h1;
        o_vec_ack <= (vec_wait_q >= i_slow);
        if (vec_wait_q >= i_slow) o_vec_data <= 32'h8000 | i_vec_addr;
      end
    end
  end
endmodule
`default_nettype wire

// [verif/nvc_irq_checker.sv]
/* Port assertions for the interrupt controller.
   Assumes a bind onto nvc_irq_ctrl, one clock, async low reset. */
`timescale 1ns/10ps
`default_nettype none
module nvc_irq_checker (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] o_prdata,
  input wire logic o_pslverr,
  input wire logic o_stk_req,
  input wire logic o_stk_push,
  input wire logic [2:0] o_stk_idx,
  input wire logic i_stk_ack,
  input wire logic o_vec_req,
  input wire logic [31:0] o_vec_addr,
  input wire logic o_branch,
  input wire logic o_handler_mode,
  input wire logic [5:0] o_active_vec,
  input wire logic i_exc_return
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  ////////////////////////////////////////
  // Holes: misaligned, past STATUS or above the window
  wire unmapped = |{i_paddr[11:8], i_paddr[1:0]} || (i_paddr[7:2] > 6'h0D);
  ////////////////////////////////////////
  chk_err_unmapped: assert property (i_psel && i_penable |-> o_pslverr == unmapped)
    else $error("slave error does not match address map");
  chk_rd_unmapped: assert property (i_psel && !i_penable && !i_pwrite && unmapped
    |=> o_prdata == 32'h0) else $error("hole read returned data");
  chk_boot_fetch: assert property ($rose(i_rst_n) |=> o_vec_req && o_vec_addr == 32'h4)
    else $error("reset vector not fetched first");
  chk_vec_map: assert property (o_vec_req |-> o_vec_addr[1:0] == 2'h0 &&
    (o_vec_addr[31:2] inside {[1:3], [16:47]})) else $error("vector address off table");
  chk_stk_start: assert property ($rose(o_stk_req) |-> o_stk_idx == 3'h0)
    else $error("stack frame not started at first word");
  chk_stk_step: assert property (o_stk_req && i_stk_ack && o_stk_idx != 3'h7
    |=> o_stk_idx == $past(o_stk_idx) + 3'h1) else $error("stack word skipped");
  chk_stk_hold: assert property (o_stk_req && !i_stk_ack
    |=> o_stk_req && $stable(o_stk_idx) && $stable(o_stk_push)) else $error("stack request dropped");
  chk_branch_pulse: assert property (o_branch |-> !o_stk_req && !o_vec_req ##1 !o_branch)
    else $error("branch overlaps entry traffic");
  chk_mode_vec: assert property (o_handler_mode == (o_active_vec != 6'h0))
    else $error("handler mode disagrees with running vector");
  chk_ret_quiet: assert property (i_exc_return |=> !o_branch)
    else $error("branch straight after return");
endmodule
bind nvc_irq_ctrl nvc_irq_checker u_nvc_irq_checker (.i_ref_clk, .i_rst_n, .i_psel,
  .i_penable, .i_pwrite, .i_paddr, .o_prdata, .o_pslverr, .o_stk_req, .o_stk_push,
  .o_stk_idx, .i_stk_ack, .o_vec_req, .o_vec_addr, .o_branch, .o_handler_mode,
  .o_active_vec, .i_exc_return);
`default_nettype wire

// [verif/nvc_irq_ctrl_test.sv]
/* Self-checking bench for the interrupt controller.
   Assumes the core model answers all stack and vector traffic. */
`timescale 1ns/10ps
`default_nettype none
`include "nvc_defines.vh"
module nvc_irq_ctrl_test;
  localparam logic [11:0] A_SETEN = {4'h0, `NVC_OFF_SETEN, 2'h0};
  localparam logic [11:0] A_CLREN = {4'h0, `NVC_OFF_CLREN, 2'h0};
  localparam logic [11:0] A_SETPEND = {4'h0, `NVC_OFF_SETPEND, 2'h0};
  localparam logic [11:0] A_CLRPEND = {4'h0, `NVC_OFF_CLRPEND, 2'h0};
  localparam logic [11:0] A_PRIO0 = {4'h0, `NVC_OFF_PRIO0, 2'h0};
  logic i_ref_clk = 1'b0, i_rst_n = 1'b0, i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
  logic i_nmi = 1'b0, i_hard_fault = 1'b0, i_power_down_wakeup_irq = 1'b0, i_exc_return = 1'b0;
  logic [2:0] i_universal_serial_irq = 3'h0, slow = 3'h0;
  logic [11:0] i_paddr = 12'h0;
  logic [31:0] i_pwdata = 32'h0, i_irq_lines = 32'h0, rd;
  logic err;
  logic [15:0] last_push = 16'h0, last_pop = 16'h0;
  wire [31:0] o_prdata, o_vec_addr, i_vec_data, o_handler_addr;
  wire o_pready, o_pslverr, o_stk_req, o_stk_push, i_stk_ack, o_vec_req, i_vec_ack;
  wire o_branch, o_handler_mode;
  wire [2:0] o_stk_idx;
  wire [5:0] o_active_vec;
  wire [15:0] n_push, n_pop;
  int mismatches = 0, n_compared = 0, cyc = 0;
  ////////////////////////////////////////
  nvc_irq_ctrl u_nvc_irq_ctrl (.i_ref_clk, .i_rst_n, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_irq_lines,
    .i_universal_serial_irq, .i_power_down_wakeup_irq, .i_nmi, .i_hard_fault, .o_stk_req,
    .o_stk_push, .o_stk_idx, .i_stk_ack, .o_vec_req, .o_vec_addr, .i_vec_ack, .i_vec_data,
    .o_branch, .o_handler_addr, .o_handler_mode, .o_active_vec, .i_exc_return);
  nvc_core_model u_nvc_core_model (.i_ref_clk, .i_rst_n, .i_slow(slow), .i_stk_req(o_stk_req),
    .i_stk_push(o_stk_push), .i_vec_req(o_vec_req), .i_vec_addr(o_vec_addr),
    .o_stk_ack(i_stk_ack), .o_vec_ack(i_vec_ack), .o_vec_data(i_vec_data),
    .o_n_push(n_push), .o_n_pop(n_pop));
  ////////////////////////////////////////
  // Clock and hang guard; a whole run is under a thousand cycles
  always #2.5 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      mismatches++;
      summarize();
    end
  end
  task automatic summarize();
    $display("mismatches %0d compared %0d", mismatches, n_compared);
    if (mismatches == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One APB transfer; released one edge before the next may start
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    i_psel <= 1'b1;
    i_pwrite <= wr;
    i_paddr <= a;
    i_pwdata <= d;
    @(posedge i_ref_clk);
    i_penable <= 1'b1;
    do @(posedge i_ref_clk); while (o_pready !== 1'b1);
    rd = o_prdata;
    err = o_pslverr;
    i_psel <= 1'b0;
    i_penable <= 1'b0;
    @(posedge i_ref_clk);
  endtask
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk("register", rd, exp);
  endtask
  // Waits for the branch; checks target, running vector, frame words
  task automatic entry(input logic [5:0] v, input logic [5:0] act, input logic [15:0] np);
    do @(posedge i_ref_clk); while (o_branch !== 1'b1);
    chk("handler", o_handler_addr, 32'h8000 | {24'h0, v, 2'h0});
    @(posedge i_ref_clk);
    chk("active", {26'h0, o_active_vec}, {26'h0, act});
    chk("pushes", {16'h0, n_push - last_push}, {16'h0, np});
    chk("pops", {16'h0, n_pop - last_pop}, 32'h0);
    last_push = n_push;
    last_pop = n_pop;
  endtask
  task automatic pulse_ret();
    i_exc_return <= 1'b1;
    @(posedge i_ref_clk);
    i_exc_return <= 1'b0;
  endtask
  task automatic ret_pop(input logic [5:0] back);
    pulse_ret();
    do @(posedge i_ref_clk); while (n_pop - last_pop < 16'h8);
    @(posedge i_ref_clk);
    chk("pops", {16'h0, n_pop - last_pop}, 32'h8);
    chk("back", {26'h0, o_active_vec}, {26'h0, back});
    last_pop = n_pop;
  endtask
  ////////////////////////////////////////
  task automatic t_regs();
    entry(6'h01, 6'h00, 16'h0);
    rdc(A_PRIO0, 32'h0);
    apb(1'b1, A_SETEN, 32'h0000_0005);
    rdc(A_CLREN, 32'h0000_0005);
    apb(1'b1, A_SETEN, 32'h0);
    apb(1'b1, A_CLREN, 32'h0000_0001);
    rdc(A_SETEN, 32'h0000_0004);
    apb(1'b1, A_CLREN, 32'h0000_0004);
    apb(1'b1, A_SETPEND, 32'h0000_0300);
    rdc(A_CLRPEND, 32'h0000_0300);
    apb(1'b1, A_CLRPEND, 32'h0000_0100);
    rdc(A_SETPEND, 32'h0000_0200);
    apb(1'b1, A_CLRPEND, 32'h0000_0200);
    apb(1'b1, A_PRIO0 + 12'h4, 32'hFFFF_FFFF);
    rdc(A_PRIO0 + 12'h4, 32'hC0C0_C0C0);
    apb(1'b1, A_PRIO0 + 12'h4, 32'h0);
    apb(1'b0, 12'h040, 32'h0);
    chk("slverr", {31'h0, err}, 32'h1);
  endtask
  task automatic t_disabled();
    i_irq_lines[5] <= 1'b1; // held until serviced
    repeat (4) @(posedge i_ref_clk);
    rdc(A_SETPEND, 32'h0000_0020);
    chk("mode", {31'h0, o_handler_mode}, 32'h0);
    apb(1'b1, A_SETEN, 32'h0000_0020);
    entry(6'h15, 6'h15, 16'h8);
    i_irq_lines[5] <= 1'b0;
    apb(1'b1, A_CLRPEND, 32'h0000_0020);
    chk("active", {26'h0, o_active_vec}, 32'h15);
    apb(1'b1, A_CLREN, 32'h0000_0020);
    chk("active", {26'h0, o_active_vec}, 32'h15);
    ret_pop(6'h00);
    apb(1'b1, A_SETPEND, 32'h0000_0020);
    chk("mode", {31'h0, o_handler_mode}, 32'h0);
    apb(1'b1, A_CLRPEND, 32'h0000_0020);
  endtask
  // Lines 1 and 2 tie at level 1; line 3 at level 3, line 0 at level 0
  task automatic t_order();
    apb(1'b1, A_PRIO0, 32'hC040_4000);
    apb(1'b1, A_SETEN, 32'h0000_000E);
    i_irq_lines[3:1] <= 3'h7;
    entry(6'h11, 6'h11, 16'h8);
    i_irq_lines[1] <= 1'b0;
    repeat (10) @(posedge i_ref_clk);
    chk("active", {26'h0, o_active_vec}, 32'h11);
    pulse_ret();
    entry(6'h12, 6'h12, 16'h0);
    i_irq_lines[2] <= 1'b0;
    repeat (4) @(posedge i_ref_clk);
    pulse_ret();
    entry(6'h13, 6'h13, 16'h0);
    apb(1'b1, A_SETEN, 32'h0000_0001);
    i_irq_lines[0] <= 1'b1;
    entry(6'h10, 6'h10, 16'h8);
    i_irq_lines[0] <= 1'b0;
    i_irq_lines[3] <= 1'b0;
    repeat (4) @(posedge i_ref_clk);
    ret_pop(6'h13);
    ret_pop(6'h00);
  endtask
  task automatic t_late();
    slow <= 3'h5;
    i_irq_lines[3] <= 1'b1;
    do @(posedge i_ref_clk); while (o_stk_req !== 1'b1);
    repeat (3) @(posedge i_ref_clk);
    i_irq_lines[0] <= 1'b1;
    entry(6'h10, 6'h10, 16'h8);
    i_irq_lines[0] <= 1'b0;
    repeat (4) @(posedge i_ref_clk);
    pulse_ret();
    entry(6'h13, 6'h13, 16'h0);
    i_irq_lines[3] <= 1'b0;
    slow <= 3'h0;
    repeat (4) @(posedge i_ref_clk);
    ret_pop(6'h00);
  endtask
  task automatic t_fixed();
    apb(1'b1, A_SETEN, 32'hFFFF_FFFF);
    i_irq_lines[16] <= 1'b1;
    repeat (4) @(posedge i_ref_clk);
    rdc(A_SETPEND, 32'h0);
    i_irq_lines[16] <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      if (k < 3) i_universal_serial_irq <= 3'h1 << k;
      else i_power_down_wakeup_irq <= 1'b1;
      entry((k < 3) ? 6'h26 : 6'h2C, (k < 3) ? 6'h26 : 6'h2C, 16'h8);
      i_universal_serial_irq <= 3'h0;
      i_power_down_wakeup_irq <= 1'b0;
      repeat (4) @(posedge i_ref_clk);
      ret_pop(6'h00);
    end
    i_irq_lines[0] <= 1'b1;
    entry(6'h10, 6'h10, 16'h8);
    i_irq_lines[0] <= 1'b0;
    i_nmi <= 1'b1;
    entry(6'h02, 6'h02, 16'h8);
    i_hard_fault <= 1'b1;
    repeat (6) @(posedge i_ref_clk);
    chk("active", {26'h0, o_active_vec}, 32'h2);
    pulse_ret();
    entry(6'h03, 6'h03, 16'h0);
    i_nmi <= 1'b0;
    i_hard_fault <= 1'b0;
    ret_pop(6'h10);
    ret_pop(6'h00);
  endtask
  ////////////////////////////////////////
  // Reset for three cycles, then the scenarios in turn
  initial begin
    repeat (3) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    t_regs();
    t_disabled();
    t_order();
    t_late();
    t_fixed();
    summarize();
  end
endmodule
`default_nettype wire
